//--- include/rcsv_defs.svh
// offsets, codes and timing counts of the pulse-input status variable bank
`ifndef RCSV_DEFS_SVH
`define RCSV_DEFS_SVH

// ----------------------------------------
// variable identifiers
// ----------------------------------------
`define RCSV_ID_LIMIT    8'h03
`define RCSV_ID_A_UNLIM  8'h04
`define RCSV_ID_A_RAW    8'h05
`define RCSV_ID_A_SCALED 8'h06
`define RCSV_ID_B_UNLIM  8'h08
`define RCSV_ID_B_RAW    8'h09
`define RCSV_ID_B_SCALED 8'h0A
`define RCSV_ID_RESET    8'h7F

// ----------------------------------------
// values and field positions
// ----------------------------------------
`define RCSV_NO_SIGNAL   16'hFFFF
`define RCSV_SCALE_MAX   27'sh0000C80
`define RCSV_KILL_LEVEL  16'sh0640
`define RCSV_LIM_PCA_BIT 5
`define RCSV_LIM_PCB_BIT 6
`define RCSV_LIM_ANA_BIT 7
`define RCSV_LIM_ANB_BIT 8
`define RCSV_LIM_USB_BIT 9
`define RCSV_RST_PIN     16'h0004
`define RCSV_RST_POWER   16'h000C
`define RCSV_RST_SOFT    16'h0014
`define RCSV_RST_WDOG    16'h0024

// ----------------------------------------
// timing
// ----------------------------------------
`define RCSV_CLK_HZ        10000000
`define RCSV_CLK_PERIOD_NS 100
`define RCSV_RES_NS        250
`define RCSV_NOSIG_MS      100
`define RCSV_NOSIG_CYCLES  (`RCSV_NOSIG_MS * (`RCSV_CLK_HZ / 1000))
`define RCSV_FLASH_MS      2000
`define RCSV_FLASH_CYCLES  (`RCSV_FLASH_MS * (`RCSV_CLK_HZ / 1000))
`define RCSV_SLOT_MS       100
`define RCSV_SLOT_CYCLES   (`RCSV_SLOT_MS * (`RCSV_CLK_HZ / 1000))

`endif

//--- include/rcsv_pkg.sv
// types shared by the pulse-input status variable bank
package rcsv_pkg;

  // ----------------------------------------
  // calibration, answer and reset cause carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] err_min;
    logic [15:0] err_max;
    logic [15:0] center;
    logic [15:0] gain;
  } rcsv_cal_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } rcsv_var_ans_type;

  typedef struct packed {
    logic power;
    logic watchdog;
    logic software;
    logic pin;
  } rcsv_cause_type;

  // ----------------------------------------
  // pulse measurement states
  // ----------------------------------------
  typedef enum logic [2:0] {
    RCSV_M_SYNC = 3'b001,
    RCSV_M_LOW = 3'b010,
    RCSV_M_HIGH = 3'b100
  } rcsv_meas_state_type;

endpackage

//--- design/rcsv_pulse_meas.sv
// high-time measurement of one receiver pulse input
`timescale 1ns/1ps
`include "rcsv_defs.svh"

module rcsv_pulse_meas #(
  parameter int NOSIG_CYCLES = `RCSV_NOSIG_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pulse_pin,
  input wire logic tick,
  output logic [15:0] width,
  output logic valid
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [15:0] cnt_r;
  logic [23:0] idle_r;
  rcsv_pkg::rcsv_meas_state_type state_r;
  rcsv_pkg::rcsv_meas_state_type state_nxt;
  wire rise = sync2_r & ~prev_r;
  wire fall = ~sync2_r & prev_r;
  wire cnt_full = (cnt_r == `RCSV_NO_SIGNAL);
  wire idle_out = (idle_r >= 24'(NOSIG_CYCLES));

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // only the second stage is looked at
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pulse_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  // start on a low at the second stage; that stage resets low, so a pulse already high at reset is half-measured
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rcsv_pkg::RCSV_M_SYNC: if (!sync2_r) state_nxt = rcsv_pkg::RCSV_M_LOW;
      rcsv_pkg::RCSV_M_LOW: if (rise) state_nxt = rcsv_pkg::RCSV_M_HIGH;
      rcsv_pkg::RCSV_M_HIGH: begin
        if (cnt_full) state_nxt = rcsv_pkg::RCSV_M_SYNC;
        else if (fall) state_nxt = rcsv_pkg::RCSV_M_LOW;
      end
      default: state_nxt = rcsv_pkg::RCSV_M_SYNC;
    endcase
  end

  // width counter in quarter-microsecond ticks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= rcsv_pkg::RCSV_M_SYNC;
      cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (rise) cnt_r <= 16'h0000;
      else if (state_r == rcsv_pkg::RCSV_M_HIGH && tick && !cnt_full) cnt_r <= cnt_r + 16'h0001;
    end
  end

  // cycles since the last rising edge; saturates so it never wraps back to valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) idle_r <= 24'h000000;
    else if (rise) idle_r <= 24'h000000;
    else if (!idle_out) idle_r <= idle_r + 24'h000001;
  end

  // latched result; over-long pulse or missing edges mean no valid signal
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      width <= 16'h0000;
      valid <= 1'b0;
    end else if (state_r == rcsv_pkg::RCSV_M_HIGH && fall && !cnt_full) begin
      width <= cnt_r;
      valid <= 1'b1;
    end else if (idle_out || cnt_full) begin
      valid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  meas_latch_a: assert property (
    state_r == rcsv_pkg::RCSV_M_HIGH && fall && !cnt_full
    |=> valid && width == $past(cnt_r)) else $error("width not latched on falling edge");
  idle_drop_a: assert property (
    idle_out && !rise |=> !valid) else $error("valid kept without edges");

endmodule // rcsv_pulse_meas

//--- design/rcsv_bank.sv
// read-only status variable bank: limit word, reset source, pulse-input values
`timescale 1ns/1ps
`include "rcsv_defs.svh"

module rcsv_bank #(
  parameter int NOSIG_CYCLES = `RCSV_NOSIG_CYCLES,
  parameter int FLASH_CYCLES = `RCSV_FLASH_CYCLES,
  parameter int SLOT_CYCLES = `RCSV_SLOT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pulse_channel_a_pin,
  input wire logic pulse_channel_b_pin,
  input wire rcsv_pkg::rcsv_cal_type cal_a,
  input wire rcsv_pkg::rcsv_cal_type cal_b,
  input wire logic pulse_channel_a_kill_cfg,
  input wire logic pulse_channel_b_kill_cfg,
  input wire logic analog_channel_a_kill_cfg,
  input wire logic analog_channel_b_kill_cfg,
  input wire logic signed [15:0] analog_channel_a_scaled,
  input wire logic signed [15:0] analog_channel_b_scaled,
  input wire logic usb_kill_active,
  input wire logic [4:0] limit_lower_bits,
  input wire rcsv_pkg::rcsv_cause_type reset_cause,
  input wire logic var_req,
  input wire logic [7:0] var_id,
  output rcsv_pkg::rcsv_var_ans_type var_ans,
  output logic led_yellow_on
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // linear scaling around the centre with an 8.8 gain, then clamped
  function automatic logic signed [15:0] scale_raw(input logic [15:0] raw,
                                                   input rcsv_pkg::rcsv_cal_type cal);
    logic signed [17:0] diff;
    logic signed [34:0] prod;
    logic signed [26:0] shifted;
    diff = $signed({2'b00, raw}) - $signed({2'b00, cal.center});
    prod = diff * $signed({1'b0, cal.gain});
    shifted = prod[34:8];
    if (raw == `RCSV_NO_SIGNAL) scale_raw = 16'sh0000;
    else if (shifted > `RCSV_SCALE_MAX) scale_raw = 16'(`RCSV_SCALE_MAX);
    else if (shifted < -`RCSV_SCALE_MAX) scale_raw = 16'(-`RCSV_SCALE_MAX);
    else scale_raw = shifted[15:0];
  endfunction

  // calibrated raw: forced to no-signal outside the error window
  function automatic logic [15:0] cal_raw(input logic ok, input logic [15:0] w,
                                          input rcsv_pkg::rcsv_cal_type cal);
    if (!ok || w < cal.err_min || w > cal.err_max) cal_raw = `RCSV_NO_SIGNAL;
    else cal_raw = w;
  endfunction

  function automatic logic kill_on(input logic cfg, input logic signed [15:0] v);
    kill_on = cfg && (v >= `RCSV_KILL_LEVEL);
  endfunction

  // ----------------------------------------
  // quarter-microsecond tick
  // ----------------------------------------
  // 100 ns clock against 250 ns resolution: ticks land 2 in every 5 cycles,
  // so a single width carries up to one count of phase jitter
  logic [8:0] frac_r;
  wire [8:0] frac_sum = frac_r + 9'(`RCSV_CLK_PERIOD_NS);
  wire tick = (frac_sum >= 9'(`RCSV_RES_NS));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) frac_r <= 9'h000;
    else frac_r <= tick ? frac_sum - 9'(`RCSV_RES_NS) : frac_sum;
  end

  // ----------------------------------------
  // pulse channels
  // ----------------------------------------
  logic [15:0] a_width;
  logic [15:0] b_width;
  logic a_valid;
  logic b_valid;

  // always running; nothing here looks at the input mode
  rcsv_pulse_meas #(.NOSIG_CYCLES(NOSIG_CYCLES)) u_meas_a (
    .clk(clk),
    .rst_b(rst_b),
    .pulse_pin(pulse_channel_a_pin),
    .tick(tick),
    .width(a_width),
    .valid(a_valid)
  );

  rcsv_pulse_meas #(.NOSIG_CYCLES(NOSIG_CYCLES)) u_meas_b (
    .clk(clk),
    .rst_b(rst_b),
    .pulse_pin(pulse_channel_b_pin),
    .tick(tick),
    .width(b_width),
    .valid(b_valid)
  );

  // derived per-channel values
  wire [15:0] a_unlim = a_valid ? a_width : `RCSV_NO_SIGNAL;
  wire [15:0] b_unlim = b_valid ? b_width : `RCSV_NO_SIGNAL;
  wire [15:0] a_raw = cal_raw(a_valid, a_width, cal_a);
  wire [15:0] b_raw = cal_raw(b_valid, b_width, cal_b);
  wire signed [15:0] a_scaled = scale_raw(a_raw, cal_a);
  wire signed [15:0] b_scaled = scale_raw(b_raw, cal_b);

  // ----------------------------------------
  // limit word
  // ----------------------------------------
  // purely combinational so a bit drops the moment its condition ends
  wire kill_pca = kill_on(pulse_channel_a_kill_cfg, a_scaled);
  wire kill_pcb = kill_on(pulse_channel_b_kill_cfg, b_scaled);
  wire kill_ana = kill_on(analog_channel_a_kill_cfg, analog_channel_a_scaled);
  wire kill_anb = kill_on(analog_channel_b_kill_cfg, analog_channel_b_scaled);
  wire [15:0] limit_word = {6'h00, usb_kill_active, kill_anb, kill_ana, kill_pcb, kill_pca,
                            limit_lower_bits};

  // ----------------------------------------
  // reset source capture
  // ----------------------------------------
  logic captured_r;
  logic [15:0] reset_code_r;
  wire [15:0] cause_code = reset_cause.power ? `RCSV_RST_POWER :
                           reset_cause.watchdog ? `RCSV_RST_WDOG :
                           reset_cause.software ? `RCSV_RST_SOFT :
                           `RCSV_RST_PIN;

  // caught on the first edge after release, never again until the next reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      captured_r <= 1'b0;
      reset_code_r <= 16'h0000;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      reset_code_r <= cause_code;
    end
  end

  // ----------------------------------------
  // start-up flash pattern
  // ----------------------------------------
  // n flashes per 8-slot frame: 1 pin, 2 power, 3 software, 4 watchdog
  logic [24:0] flash_r;
  logic [23:0] slot_cnt_r;
  logic [2:0] slot_r;
  wire flash_done = (flash_r >= 25'(FLASH_CYCLES));
  wire slot_end = (slot_cnt_r >= 24'(SLOT_CYCLES - 1));
  wire [3:0] flash_n = (reset_code_r == `RCSV_RST_POWER) ? 4'h2 :
                       (reset_code_r == `RCSV_RST_SOFT) ? 4'h3 :
                       (reset_code_r == `RCSV_RST_WDOG) ? 4'h4 : 4'h1;
  wire led_nxt = captured_r && !flash_done && !slot_r[0] &&
                 ({2'b00, slot_r} < {flash_n, 1'b0});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_r <= 25'h0000000;
      slot_cnt_r <= 24'h000000;
      slot_r <= 3'h0;
    end else if (captured_r && !flash_done) begin
      flash_r <= flash_r + 25'h0000001;
      slot_cnt_r <= slot_end ? 24'h000000 : slot_cnt_r + 24'h000001;
      if (slot_end) slot_r <= slot_r + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) led_yellow_on <= 1'b0;
    else led_yellow_on <= led_nxt;
  end

  // ----------------------------------------
  // variable requests
  // ----------------------------------------
  // plain mux with no strobe back into any store, so reads are free of effects
  wire [15:0] sel_data = (var_id == `RCSV_ID_LIMIT) ? limit_word :
                         (var_id == `RCSV_ID_A_UNLIM) ? a_unlim :
                         (var_id == `RCSV_ID_A_RAW) ? a_raw :
                         (var_id == `RCSV_ID_A_SCALED) ? a_scaled :
                         (var_id == `RCSV_ID_B_UNLIM) ? b_unlim :
                         (var_id == `RCSV_ID_B_RAW) ? b_raw :
                         (var_id == `RCSV_ID_B_SCALED) ? b_scaled :
                         (var_id == `RCSV_ID_RESET) ? reset_code_r : 16'h0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      var_ans <= '0;
    end else begin
      var_ans.valid <= var_req;
      if (var_req) var_ans.data <= sel_data;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // answer timing and per-channel values
  answer_next_a: assert property (
    var_req |=> var_ans.valid ##1 (var_ans.valid == $past(var_req)))
    else $error("answer not one cycle after request");
  nosig_raw_a: assert property (
    var_req && var_id == `RCSV_ID_A_RAW && !a_valid |=> var_ans.data == 16'hFFFF)
    else $error("no-signal raw not 0xFFFF");
  nosig_unlim_a: assert property (
    var_req && var_id == `RCSV_ID_A_UNLIM && !a_valid |=> var_ans.data == 16'hFFFF)
    else $error("no-signal unlimited raw not 0xFFFF");
  bounds_raw_a: assert property (
    var_req && var_id == `RCSV_ID_B_RAW && b_valid &&
    (b_width < cal_b.err_min || b_width > cal_b.err_max) |=> var_ans.data == 16'hFFFF)
    else $error("out-of-bounds raw not forced");
  unlim_keeps_a: assert property (
    var_req && var_id == `RCSV_ID_A_UNLIM && a_valid |=> var_ans.data == $past(a_width))
    else $error("unlimited raw lost width");
  unlim_b_a: assert property (
    var_req && var_id == `RCSV_ID_B_UNLIM && b_valid |=> var_ans.data == $past(b_width))
    else $error("channel b unlimited raw not at its id");
  scaled_zero_a: assert property (
    var_req && var_id == `RCSV_ID_B_SCALED && b_raw == 16'hFFFF
    |=> var_ans.data == 16'h0000)
    else $error("scaled not zero for no signal");
  scale_range_a: assert property (
    a_scaled <= 16'sh0C80 && a_scaled >= -16'sh0C80 &&
    b_scaled <= 16'sh0C80 && b_scaled >= -16'sh0C80)
    else $error("scaled value out of range");

  // limit word, read back against the live inputs of the request cycle
  kill_bit_a: assert property (
    var_req && var_id == `RCSV_ID_LIMIT
    |=> var_ans.data[5] == $past(pulse_channel_a_kill_cfg && a_scaled >= 16'sh0640) &&
        var_ans.data[9] == $past(usb_kill_active) && var_ans.data[15:10] == 6'h00)
    else $error("limit word bits wrong");
  kill_other_a: assert property (
    var_req && var_id == `RCSV_ID_LIMIT
    |=> var_ans.data[6] == $past(pulse_channel_b_kill_cfg && b_scaled >= 16'sh0640) &&
        var_ans.data[7] == $past(analog_channel_a_kill_cfg &&
                                 analog_channel_a_scaled >= 16'sh0640) &&
        var_ans.data[8] == $past(analog_channel_b_kill_cfg &&
                                 analog_channel_b_scaled >= 16'sh0640))
    else $error("kill bits 6 to 8 wrong");
  lower_pass_a: assert property (
    var_req && var_id == `RCSV_ID_LIMIT |=> var_ans.data[4:0] == $past(limit_lower_bits))
    else $error("lower limit bits not passed through");

  // reset source and indicator
  code_hold_a: assert property (
    captured_r && $past(captured_r) |-> $stable(reset_code_r))
    else $error("reset code changed while running");
  read_quiet_a: assert property (
    captured_r && var_req |=> reset_code_r == $past(reset_code_r) && captured_r)
    else $error("read disturbed the reset code");
  code_value_a: assert property (
    $rose(captured_r) && $past(reset_cause.watchdog) &&
    !$past(reset_cause.power) |-> reset_code_r == 16'h0024)
    else $error("watchdog code wrong");
  code_soft_a: assert property (
    $rose(captured_r) && $past(reset_cause.software) && !$past(reset_cause.watchdog) &&
    !$past(reset_cause.power) |-> reset_code_r == 16'h0014)
    else $error("software code wrong");
  code_power_a: assert property (
    $rose(captured_r) && $past(reset_cause.power) |-> reset_code_r == 16'h000C)
    else $error("power code wrong");
  code_pin_a: assert property (
    $rose(captured_r) && $past(reset_cause) == 4'h1 |-> reset_code_r == 16'h0004)
    else $error("pin code wrong");
  flash_off_a: assert property (
    flash_done |=> !led_yellow_on)
    else $error("indicator flashing after window");
  led_start_a: assert property (
    !captured_r |=> !led_yellow_on)
    else $error("indicator lit before capture");

  // main scenarios: channel reads, kill drop, flash, reset read, out-of-bounds raw
  cov_a_read_c: cover property (var_req && var_id == `RCSV_ID_A_SCALED && a_valid);
  cov_kill_c: cover property (kill_pca ##1 !kill_pca);
  cov_flash_c: cover property ($rose(led_yellow_on));
  cov_reset_read_c: cover property (var_req && var_id == `RCSV_ID_RESET);
  cov_bounds_c: cover property (var_req && var_id == `RCSV_ID_B_RAW && b_valid &&
    b_raw == 16'hFFFF);

endmodule // rcsv_bank

//--- testbench/rcsv_rx_model.sv
// receiver model: one pulse channel with a bench-set high time
`timescale 1ns/1ps

module rcsv_rx_model (
  input wire logic en,
  input wire logic [31:0] high_ns,
  output logic pin
);
  // ----------------------------------------
  // pulse train
  // ----------------------------------------
  // free-running in ns, not locked to the clock; a high_ns that is a multiple of 100 puts every edge on a falling clock edge
  // the line idles low while disabled, as an unplugged receiver would
  initial begin
    pin = 1'b0;
    forever begin
      if (en) begin
        pin = 1'b1;
        #(high_ns);
        pin = 1'b0;
      end
      #30000;
    end
  end
endmodule // rcsv_rx_model

//--- testbench/rcsv_bank_tb.sv
// self-checking bench for the pulse-input status variable bank
`timescale 1ns/1ps
`include "rcsv_defs.svh"

module rcsv_bank_tb;
  typedef struct {
    logic [3:0] cfg;
    logic [15:0] an_a;
    logic [15:0] an_b;
    logic usb;
    logic [4:0] low;
    logic [15:0] exp;
  } rcsv_row_type;

  logic clk, rst_b, pa_en, pb_en, pa_pin, pb_pin, var_req, led, usb;
  logic pa_k, pb_k, ana_k, anb_k;
  logic signed [15:0] an_a, an_b;
  logic [4:0] low;
  logic [7:0] var_id;
  rcsv_pkg::rcsv_cal_type cal_a, cal_b;
  rcsv_pkg::rcsv_cause_type cause;
  rcsv_pkg::rcsv_var_ans_type var_ans;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  // cfg bits are {pa, pb, analog a, analog b}; channel b has no signal here
  rcsv_row_type rows[9] = '{
    '{4'h0, 16'h0000, 16'h0000, 1'b0, 5'h00, 16'h0000},
    '{4'h8, 16'h0000, 16'h0000, 1'b0, 5'h00, 16'h0020},
    '{4'h4, 16'h0000, 16'h0000, 1'b0, 5'h00, 16'h0000},
    '{4'h2, 16'h0640, 16'h0000, 1'b0, 5'h00, 16'h0080},
    '{4'h2, 16'h063F, 16'h0000, 1'b0, 5'h00, 16'h0000},
    '{4'h1, 16'h0000, 16'h0C80, 1'b0, 5'h00, 16'h0100},
    '{4'h3, 16'hFFFF, 16'h0640, 1'b1, 5'h1F, 16'h031F},
    '{4'h0, 16'h0000, 16'h0C80, 1'b1, 5'h00, 16'h0200},
    '{4'hF, 16'h0640, 16'h0640, 1'b1, 5'h15, 16'h03B5}};
  logic [3:0] cz[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF};
  logic [15:0] rc[5] = '{16'h000C, 16'h0024, 16'h0014, 16'h0004, 16'h000C};
  int ln[5] = '{2, 4, 3, 1, 2};

  // ----------------------------------------
  // design and receiver models
  // ----------------------------------------
  rcsv_bank #(.NOSIG_CYCLES(2000), .FLASH_CYCLES(400), .SLOT_CYCLES(20)) i_dut (
    .clk(clk), .rst_b(rst_b), .pulse_channel_a_pin(pa_pin), .pulse_channel_b_pin(pb_pin),
    .cal_a(cal_a), .cal_b(cal_b), .pulse_channel_a_kill_cfg(pa_k),
    .pulse_channel_b_kill_cfg(pb_k), .analog_channel_a_kill_cfg(ana_k),
    .analog_channel_b_kill_cfg(anb_k), .analog_channel_a_scaled(an_a),
    .analog_channel_b_scaled(an_b), .usb_kill_active(usb), .limit_lower_bits(low),
    .reset_cause(cause), .var_req(var_req), .var_id(var_id), .var_ans(var_ans),
    .led_yellow_on(led));
  rcsv_rx_model i_rx_a (.en(pa_en), .high_ns(32'd20000), .pin(pa_pin));
  rcsv_rx_model i_rx_b (.en(pb_en), .high_ns(32'd30000), .pin(pb_pin));

  // ----------------------------------------
  // clock, timeout, compares
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // whole run needs about 9000 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // widths carry one count of jitter, so they are checked against a window
  task automatic chk_rng(input string nm, input logic [15:0] lo, input logic [15:0] hi,
                         input logic [15:0] g);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      mismatches++;
      $display("ERROR %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // host side: reset, variable read, expected scaling
  // ----------------------------------------
  task automatic do_reset(input logic [3:0] c);
    @(negedge clk);
    rst_b = 1'b0;
    cause = c;
    repeat (5) @(negedge clk);
    chk_val("answer in reset", 16'h0000, var_ans.data);
    chk_bit("led in reset", 1'b0, led);
    rst_b = 1'b1;
  endtask

  task automatic rd(input logic [7:0] id, output logic [15:0] d);
    int n;
    @(negedge clk);
    var_req = 1'b1;
    var_id = id;
    @(negedge clk);
    var_req = 1'b0;
    n = 0;
    while (var_ans.valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk_bit("answer valid", 1'b1, var_ans.valid);
    d = var_ans.data;
  endtask

  function automatic logic [15:0] scale(input logic [15:0] raw, input rcsv_pkg::rcsv_cal_type cal);
    int v;
    v = ((int'(raw) - int'(cal.center)) * int'(cal.gain)) >>> 8;
    if (raw == 16'hFFFF) v = 0;
    if (v > 3200) v = 3200;
    if (v < -3200) v = -3200;
    return v[15:0];
  endfunction

  // reads just after a pulse ends, so all three values share one width
  task automatic chk_ch(input logic ch, input logic [15:0] lo, input logic [15:0] hi,
                        input rcsv_pkg::rcsv_cal_type cal);
    logic [7:0] base;
    logic [15:0] u, r, e;
    base = ch ? `RCSV_ID_B_UNLIM : `RCSV_ID_A_UNLIM;
    if (ch) @(negedge pb_pin);
    else @(negedge pa_pin);
    repeat (10) @(negedge clk);
    rd(base, u);
    chk_rng("unlimited width", lo, hi, u);
    e = (u >= cal.err_min && u <= cal.err_max) ? u : 16'hFFFF;
    rd(base + 8'h01, r);
    chk_val("raw width", e, r);
    rd(base + 8'h02, r);
    chk_val("scaled value", scale(e, cal), r);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i;
    logic [15:0] d;
    rst_b = 1'b0;
    pa_en = 1'b0;
    pb_en = 1'b0;
    {pa_k, pb_k, ana_k, anb_k} = 4'h0;
    an_a = 16'sh0000;
    an_b = 16'sh0000;
    usb = 1'b0;
    low = 5'h00;
    cause = 4'h0;
    var_req = 1'b0;
    var_id = 8'h00;
    cal_a = '{16'h0000, 16'hFFFE, 16'h0000, 16'h2000};
    cal_b = '{16'h0000, 16'hFFFE, 16'h0000, 16'h1400};
    // each cause, priority case last, with its indicator pattern
    for (i = 0; i < 5; i++) begin
      do_reset(cz[i]);
      repeat (10) @(negedge clk);
      chk_bit("led slot 0", 1'b1, led);
      repeat (20) @(negedge clk);
      chk_bit("led slot 1", 1'b0, led);
      repeat (20) @(negedge clk);
      chk_bit("led slot 2", ln[i] >= 2, led);
      rd(`RCSV_ID_RESET, d);
      chk_val("reset code", rc[i], d);
      cause = 4'h0;
      rd(`RCSV_ID_RESET, d);
      chk_val("reset code held", rc[i], d);
      repeat (400) @(negedge clk);
      chk_bit("led after flash", 1'b0, led);
    end
    do_reset(4'h1);
    pa_en = 1'b1;
    repeat (1200) @(negedge clk);
    // limit word rows
    for (i = 0; i < 9; i++) begin
      {pa_k, pb_k, ana_k, anb_k} = rows[i].cfg;
      an_a = rows[i].an_a;
      an_b = rows[i].an_b;
      usb = rows[i].usb;
      low = rows[i].low;
      rd(`RCSV_ID_LIMIT, d);
      chk_val("limit word", rows[i].exp, d);
    end
    // in range, out of bounds, then both clamp limits
    chk_ch(1'b0, 16'h004F, 16'h0051, cal_a);
    cal_a.err_max = 16'h0032;
    chk_ch(1'b0, 16'h004F, 16'h0051, cal_a);
    cal_a.err_max = 16'hFFFE;
    cal_a.gain = 16'h6400;
    chk_ch(1'b0, 16'h004F, 16'h0051, cal_a);
    cal_a.center = 16'h03E8;
    chk_ch(1'b0, 16'h004F, 16'h0051, cal_a);
    pb_en = 1'b1;
    chk_ch(1'b1, 16'h0077, 16'h0079, cal_b);
    {pa_k, pb_k, ana_k, anb_k} = 4'h4;
    {usb, low} = 6'h00;
    rd(`RCSV_ID_LIMIT, d);
    chk_val("limit word b", 16'h0040, d);
    rd(8'h07, d);
    chk_val("unmapped id", 16'h0000, d);
    // channel b below its error minimum: raw forced, scaled zero
    cal_b.err_min = 16'h0100;
    chk_ch(1'b1, 16'h0077, 16'h0079, cal_b);
    // signal lost on channel a
    pa_en = 1'b0;
    repeat (2600) @(negedge clk);
    for (i = 0; i < 3; i++) begin
      rd(`RCSV_ID_A_UNLIM + i[7:0], d);
      chk_val("no signal", (i == 2) ? 16'h0000 : 16'hFFFF, d);
    end
    test_done();
  end
endmodule // rcsv_bank_tb
